// *** design/sso_defines.vh ***
// sso_defines.vh: offsets, field positions, warning codes and timing counts
// assumes: included by the servo status output design, its assertion module and its bench
`ifndef SSO_DEFINES_VH
`define SSO_DEFINES_VH
// apb register byte offsets
`define SSO_A_CTRL      12'h000
`define SSO_A_POS       12'h004
`define SSO_A_WLO       12'h008
`define SSO_A_WHI       12'h00C
`define SSO_A_TLIM1     12'h010
`define SSO_A_TLIM2     12'h014
`define SSO_A_TORQ      12'h018
`define SSO_A_WARN      12'h01C
`define SSO_A_PCMD      12'h020
`define SSO_A_OFFT1     12'h024
`define SSO_A_OFFT2     12'h028
`define SSO_A_OFFT3     12'h02C
`define SSO_A_STAT      12'h030
`define SSO_A_IRQS      12'h034
`define SSO_A_IRQM      12'h038
// ctrl fields
`define SSO_C_HOMED     0
`define SSO_C_BASE_ON   1
`define SSO_C_ALARM     2
`define SSO_C_ALM_RST   3
`define SSO_C_DECEL     4
`define SSO_C_TLA_EN    5
// program command fields: [1:0] index, bit 8 set, bit 9 clear
`define SSO_P_IDX_HI    1
`define SSO_P_IDX_LO    0
`define SSO_P_SET       8
`define SSO_P_CLR       9
// warning code fields
`define SSO_W_ANY       8
`define SSO_CODE_BCABLE 8'h92
`define SSO_CODE_BATT   8'h9F
// status bits
`define SSO_S_POS       0
`define SSO_S_WARN      1
`define SSO_S_BATT      2
`define SSO_S_TLIM      3
`define SSO_S_STOP      4
`define SSO_S_PROGRAM_OUTPUT_ONE      5
`define SSO_S_PROGRAM_OUTPUT_TWO      6
`define SSO_S_PROGRAM_OUTPUT_THREE      7
`define SSO_S_NBITS     8
// timing
`define SSO_CLK_NS      50
`define SSO_SETTLE_NS   1000000000
`define SSO_OFF_TICK_NS 1000000
`define SSO_ZERO32      32'h00000000
`endif

// *** design/sso_off_timer.v ***
// sso_off_timer.v: one program output with set, clear and auto turn-off
// assumes: set, clr and tick are single-cycle pulses on the same clock
`timescale 1ns/1ps
`default_nettype none
module sso_off_timer (
  input  wire        clk,
  input  wire        nrst,
  input  wire        set,
  input  wire        clr,
  input  wire        tick,
  input  wire [15:0] off_time,
  output reg         out_q
);
  reg  [15:0] cnt_q;

  always @(posedge clk) begin
    if (!nrst) begin
      out_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else if (set) begin
      out_q <= 1'b1;
      cnt_q <= off_time;
    end else if (clr) begin
      out_q <= 1'b0;
    end else if (out_q && tick && (cnt_q != 16'h0000)) begin
      // zero time means hold until an explicit clear
      cnt_q <= cnt_q - 16'h0001;
      if (cnt_q == 16'h0001) out_q <= 1'b0;
    end
  end
endmodule // sso_off_timer
`default_nettype wire

// *** design/sso_status.v ***
// sso_status.v: discrete servo status outputs with apb register access
// assumes: apb master on CORE_CLK; STOP_RESTART_IN is an async pin
`timescale 1ns/1ps
`default_nettype none
`include "sso_defines.vh"
//////////////////////////////////////////////////////////////////////////////
module sso_status #(
  parameter SETTLE_CYC = `SSO_SETTLE_NS / `SSO_CLK_NS,
  parameter TICK_CYC   = `SSO_OFF_TICK_NS / `SSO_CLK_NS
) (
  input  wire        CORE_CLK,
  input  wire        NRST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        STOP_RESTART_IN,
  input  wire [9:0]  ANALOG_TORQUE_LIMIT,
  output reg         POSITION_IN_RANGE,
  output reg         GENERAL_WARNING,
  output reg         BATTERY_WARNING,
  output reg         TORQUE_LIMITING,
  output reg         TEMPORARY_STOP_ACTIVE,
  output wire        PROGRAM_OUTPUT_ONE,
  output wire        PROGRAM_OUTPUT_TWO,
  output wire        PROGRAM_OUTPUT_THREE,
  output reg         IRQ
);
  reg  [5:0]  ctrl_q;
  reg  [31:0] pos_q;
  reg  [31:0] wlo_q;
  reg  [31:0] whi_q;
  reg  [15:0] tlim1_q;
  reg  [15:0] tlim2_q;
  reg  [15:0] torq_q;
  reg  [8:0]  warn_q;
  reg  [15:0] offt_q [0:2];
  reg  [7:0]  irqs_q;
  reg  [7:0]  irqm_q;
  reg  [7:0]  stat_prev_q;
  reg  [31:0] settle_q;
  reg         settled_q;
  reg  [31:0] tick_cnt_q;
  reg         tick_q;
  reg         stp_m_q;
  reg         stp_s_q;
  reg         stp_p_q;
  reg  [2:0]  set_q;
  reg         clr_q;
  wire [2:0]  pout;
  wire [7:0]  stat;
  wire        wr;
  wire        rd;
  wire        stp_rise;
  wire        base_on;
  wire        in_win;
  wire [15:0] tla_scaled;
  wire        tlim_hit;
  wire [1:0]  pidx;
  integer     i;
  reg  [31:0] rdata_d;
  reg         slverr_d;
  reg         pos_d;
  reg         warn_d;
  reg         batt_d;
  reg         tlim_d;
  reg         stop_d;
  wire        batt_code;
  wire        irqs_clr;
  wire        lo_ok;
  wire        hi_ok;

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, unmapped reads zero with slverr
  assign wr = PSEL && PENABLE && PWRITE && PREADY;
  assign rd = PSEL && PENABLE && !PWRITE && PREADY;
  assign pidx = PWDATA[`SSO_P_IDX_HI:`SSO_P_IDX_LO];

  always @(posedge CORE_CLK) begin
    if (!NRST) begin
      ctrl_q  <= 6'h00;
      pos_q   <= 32'h00000000;
      wlo_q   <= 32'h00000000;
      whi_q   <= 32'h00000000;
      tlim1_q <= 16'hFFFF;
      tlim2_q <= 16'hFFFF;
      torq_q  <= 16'h0000;
      warn_q  <= 9'h000;
      irqm_q  <= 8'h00;
      set_q   <= 3'h0;
      clr_q   <= 1'b0;
      PREADY  <= 1'b0;
      for (i = 0; i < 3; i = i + 1) offt_q[i] <= 16'h0000;
    end else begin
      PREADY <= PSEL && !PENABLE;
      set_q  <= 3'h0;
      clr_q  <= 1'b0;
      if (wr) begin
        case (PADDR)
          `SSO_A_CTRL:  ctrl_q  <= PWDATA[5:0];
          `SSO_A_POS:   pos_q   <= PWDATA;
          `SSO_A_WLO:   wlo_q   <= PWDATA;
          `SSO_A_WHI:   whi_q   <= PWDATA;
          `SSO_A_TLIM1: tlim1_q <= PWDATA[15:0];
          `SSO_A_TLIM2: tlim2_q <= PWDATA[15:0];
          `SSO_A_TORQ:  torq_q  <= PWDATA[15:0];
          `SSO_A_WARN:  warn_q  <= PWDATA[8:0];
          `SSO_A_OFFT1: offt_q[0] <= PWDATA[15:0];
          `SSO_A_OFFT2: offt_q[1] <= PWDATA[15:0];
          `SSO_A_OFFT3: offt_q[2] <= PWDATA[15:0];
          `SSO_A_IRQM:  irqm_q  <= PWDATA[7:0];
          // index zero names no output, so a set with it does nothing
          `SSO_A_PCMD: begin
            if (PWDATA[`SSO_P_SET] && pidx != 2'b00) begin
              set_q <= 3'b001 << (pidx - 2'b01);
            end
            clr_q <= PWDATA[`SSO_P_CLR];
          end
          default: ;
        endcase
      end
    end
  end

  // read mux decoded in the setup cycle so data stands through the access
  always @* begin
    rdata_d  = `SSO_ZERO32;
    slverr_d = 1'b0;
    case (PADDR)
      `SSO_A_CTRL:  rdata_d = {26'h0000000, ctrl_q};
      `SSO_A_POS:   rdata_d = pos_q;
      `SSO_A_WLO:   rdata_d = wlo_q;
      `SSO_A_WHI:   rdata_d = whi_q;
      `SSO_A_TLIM1: rdata_d = {16'h0000, tlim1_q};
      `SSO_A_TLIM2: rdata_d = {16'h0000, tlim2_q};
      `SSO_A_TORQ:  rdata_d = {16'h0000, torq_q};
      `SSO_A_WARN:  rdata_d = {23'h000000, warn_q};
      `SSO_A_PCMD:  rdata_d = `SSO_ZERO32;
      `SSO_A_OFFT1: rdata_d = {16'h0000, offt_q[0]};
      `SSO_A_OFFT2: rdata_d = {16'h0000, offt_q[1]};
      `SSO_A_OFFT3: rdata_d = {16'h0000, offt_q[2]};
      `SSO_A_STAT:  rdata_d = {24'h000000, stat};
      `SSO_A_IRQS:  rdata_d = {24'h000000, irqs_q};
      `SSO_A_IRQM:  rdata_d = {24'h000000, irqm_q};
      default:      slverr_d = 1'b1;
    endcase
  end

  always @(posedge CORE_CLK) begin
    if (!NRST) begin
      PRDATA  <= `SSO_ZERO32;
      PSLVERR <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      PRDATA  <= rdata_d;
      PSLVERR <= slverr_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // power-on settle window: warnings read high until it has passed
  always @(posedge CORE_CLK) begin
    if (!NRST) begin
      settle_q  <= `SSO_ZERO32;
      settled_q <= 1'b0;
    end else if (!settled_q) begin
      // counter stops once settled, so it never wraps back
      settle_q <= settle_q + 32'h00000001;
      if (settle_q == SETTLE_CYC - 1) settled_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // turn-off time base: one tick per 1 ms, free running
  // free running, so an off time of n lasts between n-1 and n ticks
  always @(posedge CORE_CLK) begin
    if (!NRST) begin
      tick_cnt_q <= `SSO_ZERO32;
      tick_q     <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_CYC - 1);
      if (tick_cnt_q == TICK_CYC - 1) begin
        tick_cnt_q <= `SSO_ZERO32;
      end else begin
        tick_cnt_q <= tick_cnt_q + 32'h00000001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // stop/restart pin synchroniser and status logic
  always @(posedge CORE_CLK) begin
    if (!NRST) begin
      stp_m_q <= 1'b0;
      stp_s_q <= 1'b0;
      stp_p_q <= 1'b0;
    end else begin
      stp_m_q <= STOP_RESTART_IN;
      stp_s_q <= stp_m_q;
      stp_p_q <= stp_s_q;
    end
  end
  // stage one feeds only stage two
  assign stp_rise = stp_s_q && !stp_p_q;

  assign base_on = ctrl_q[`SSO_C_BASE_ON] && !ctrl_q[`SSO_C_ALARM]
                   && !ctrl_q[`SSO_C_ALM_RST];
  // signed compare: positions may be negative
  assign lo_ok  = $signed(pos_q) >= $signed(wlo_q);
  assign hi_ok  = $signed(pos_q) <= $signed(whi_q);
  assign in_win = lo_ok && hi_ok;
  // 10-bit analog limit scaled to the torque word
  assign tla_scaled = {ANALOG_TORQUE_LIMIT, 6'h00};
  assign tlim_hit = (torq_q >= tlim1_q) || (torq_q >= tlim2_q)
                    || (ctrl_q[`SSO_C_TLA_EN] && torq_q >= tla_scaled);

  assign batt_code = (warn_q[7:0] == `SSO_CODE_BCABLE)
                     || (warn_q[7:0] == `SSO_CODE_BATT);

  // next values of the status outputs
  always @* begin
    pos_d  = in_win && ctrl_q[`SSO_C_HOMED] && base_on;
    // warnings read high until the settle window passes
    warn_d = warn_q[`SSO_W_ANY] || !settled_q;
    batt_d = (warn_q[`SSO_W_ANY] && batt_code) || !settled_q;
    tlim_d = tlim_hit;
    stop_d = TEMPORARY_STOP_ACTIVE;
    if (stp_rise && !TEMPORARY_STOP_ACTIVE && ctrl_q[`SSO_C_DECEL]) begin
      stop_d = 1'b1;
    end else if (stp_rise && TEMPORARY_STOP_ACTIVE) begin
      // restart press: drop as motion resumes
      stop_d = 1'b0;
    end
  end

  always @(posedge CORE_CLK) begin
    if (!NRST) begin
      POSITION_IN_RANGE     <= 1'b0;
      GENERAL_WARNING       <= 1'b1;
      BATTERY_WARNING       <= 1'b1;
      TORQUE_LIMITING       <= 1'b0;
      TEMPORARY_STOP_ACTIVE <= 1'b0;
    end else begin
      POSITION_IN_RANGE     <= pos_d;
      GENERAL_WARNING       <= warn_d;
      BATTERY_WARNING       <= batt_d;
      TORQUE_LIMITING       <= tlim_d;
      TEMPORARY_STOP_ACTIVE <= stop_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // program outputs
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pout
      sso_off_timer u_tmr (
        .clk      (CORE_CLK),
        .nrst     (NRST),
        .set      (set_q[g]),
        .clr      (clr_q),
        .tick     (tick_q),
        .off_time (offt_q[g]),
        .out_q    (pout[g])
      );
    end
  endgenerate
  assign PROGRAM_OUTPUT_ONE   = pout[0];
  assign PROGRAM_OUTPUT_TWO   = pout[1];
  assign PROGRAM_OUTPUT_THREE = pout[2];

  //////////////////////////////////////////////////////////////////////////////
  // interrupts: rising edge of any status bit, cleared by reading, set wins
  assign stat = {pout, TEMPORARY_STOP_ACTIVE, TORQUE_LIMITING, BATTERY_WARNING,
                 GENERAL_WARNING, POSITION_IN_RANGE};
  assign irqs_clr = rd && (PADDR == `SSO_A_IRQS);
  always @(posedge CORE_CLK) begin
    if (!NRST) begin
      irqs_q      <= 8'h00;
      stat_prev_q <= 8'h00;
      IRQ         <= 1'b0;
    end else begin
      stat_prev_q <= stat;
      // a rise in the clearing cycle survives the read
      irqs_q <= (irqs_clr ? 8'h00 : irqs_q) | (stat & ~stat_prev_q);
      IRQ    <= |(irqs_q & irqm_q);
    end
  end
endmodule // sso_status
`default_nettype wire

// *** tb/sso_host_model.sv ***
// sso_host_model.sv: host side pressing the stop/restart pin
// assumes: go is a one-cycle request from the bench
`timescale 1ns/1ps
`default_nettype none
module sso_host_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [3:0] hold,
  output var  logic       stop_pin
);
  logic [3:0] cnt_q;
  initial begin
    stop_pin = 1'b0;
    cnt_q = 4'h0;
  end
  // hold sets a short or long press; a second press asks to resume
  always @(posedge clk) begin
    if (go) begin
      stop_pin <= 1'b1;
      cnt_q <= hold;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else begin
      stop_pin <= 1'b0;
    end
  end
endmodule // sso_host_model
`default_nettype wire

// *** tb/sso_status_sva.sv ***
// sso_status_sva.sv: port checks on the servo status block
// assumes: bound into sso_status; one clock, sync low reset
`timescale 1ns/1ps
`default_nettype none
`include "sso_defines.vh"
module sso_status_sva (
  input wire logic        CORE_CLK,
  input wire logic        NRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        STOP_RESTART_IN,
  input wire logic        GENERAL_WARNING,
  input wire logic        BATTERY_WARNING,
  input wire logic        TEMPORARY_STOP_ACTIVE,
  input wire logic        PROGRAM_OUTPUT_ONE,
  input wire logic        PROGRAM_OUTPUT_THREE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  ////////////////////////////////////////
  // pin history; sync stages leave slack on the exact edge
  logic [6:0] pin_h_q;
  always_ff @(posedge CORE_CLK) pin_h_q <= {pin_h_q[5:0], STOP_RESTART_IN};
  wire pin_rose = |(pin_h_q[5:2] & ~pin_h_q[6:3]);
  wire cmd = PSEL && PENABLE && PREADY && PWRITE && PADDR == `SSO_A_PCMD && PWDATA[8];
  wire set1 = cmd && PWDATA[1:0] == 2'h1;
  wire set3 = cmd && PWDATA[1:0] == 2'h3;
  sequence s_setup; PSEL && !PENABLE; endsequence
  sequence s_access; PSEL && PENABLE && PREADY; endsequence
  ready_next_a: assert property (s_setup |=> s_access) else $error("no ready");
  ready_held_a: assert property (PREADY |-> PSEL && PENABLE) else $error("stray ready");
  ready_once_a: assert property (s_access |=> !PREADY) else $error("ready too long");
  bad_addr_a: assert property (s_access ##0 PADDR[11:6] != 6'h00 |-> PSLVERR)
    else $error("no error on unmapped");
  warn_settle_a: assert property ($rose(NRST) |-> (GENERAL_WARNING && BATTERY_WARNING) [*8])
    else $error("warnings dropped early");
  stop_cause_a: assert property ($changed(TEMPORARY_STOP_ACTIVE) |-> pin_rose)
    else $error("stop flag moved alone");
  program_output_one_set_a: assert property ($rose(PROGRAM_OUTPUT_ONE) |-> $past(set1, 2) || $past(set1, 3))
    else $error("out one rose alone");
  program_output_three_set_a: assert property ($rose(PROGRAM_OUTPUT_THREE) |-> $past(set3, 2) || $past(set3, 3))
    else $error("out three rose alone");
endmodule // sso_status_sva
bind sso_status sso_status_sva u_sva (.CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .STOP_RESTART_IN(STOP_RESTART_IN), .GENERAL_WARNING(GENERAL_WARNING),
  .BATTERY_WARNING(BATTERY_WARNING), .TEMPORARY_STOP_ACTIVE(TEMPORARY_STOP_ACTIVE),
  .PROGRAM_OUTPUT_ONE(PROGRAM_OUTPUT_ONE), .PROGRAM_OUTPUT_THREE(PROGRAM_OUTPUT_THREE));
`default_nettype wire

// *** tb/tb_sso_status.sv ***
// tb_sso_status.sv: self-checking bench for sso_status
// assumes: this bench is the apb master; host model drives the pin
`timescale 1ns/1ps
`default_nettype none
`include "sso_defines.vh"
module tb_sso_status;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic        go = 1'b0;
  logic        e;
  logic [3:0]  hold = 4'h1;
  logic [9:0]  atl = 10'h000;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [31:0] rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, temp_stop_restart_input, pos, gw, bw, tl, ts, irq;
  wire  [2:0]  outs;
  int          err_total = 0;
  int          cmp_count = 0;
  always #25 clk = ~clk;
  sso_status #(.SETTLE_CYC(50), .TICK_CYC(4)) u_dut (.CORE_CLK(clk), .NRST(nrst),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .STOP_RESTART_IN(temp_stop_restart_input), .ANALOG_TORQUE_LIMIT(atl),
    .POSITION_IN_RANGE(pos), .GENERAL_WARNING(gw), .BATTERY_WARNING(bw),
    .TORQUE_LIMITING(tl), .TEMPORARY_STOP_ACTIVE(ts), .PROGRAM_OUTPUT_ONE(outs[0]),
    .PROGRAM_OUTPUT_TWO(outs[1]), .PROGRAM_OUTPUT_THREE(outs[2]), .IRQ(irq));
  sso_host_model u_host (.clk(clk), .go(go), .hold(hold), .stop_pin(temp_stop_restart_input));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // only the watchdog ends a wait that never sees ready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // write, then let the outputs catch up
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    repeat (3) @(posedge clk);
  endtask
  task automatic press(input logic [3:0] h);
    hold <= h;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (14) @(posedge clk);
  endtask
  ////////////////////////////////////////
  task automatic t_misc();
    logic [31:0] c [4] = '{32'h1, 32'h2, 32'h7, 32'hB};
    logic [31:0] v [4] = '{32'h192, 32'h19F, 32'h150, 32'h0};
    logic [1:0]  x [4] = '{2'h3, 2'h3, 2'h2, 2'h0};
    chk({gw, bw}, 2'h3);
    repeat (60) @(posedge clk);
    chk({gw, bw}, 2'h0);
    wr(`SSO_A_WLO, 32'hA);
    wr(`SSO_A_WHI, 32'h14);
    wr(`SSO_A_POS, 32'h14);
    wr(`SSO_A_CTRL, 32'h3);
    chk(pos, 1'b1);
    foreach (c[i]) begin
      wr(`SSO_A_CTRL, c[i]);
      chk(pos, 1'b0);
    end
    wr(`SSO_A_CTRL, 32'h3);
    wr(`SSO_A_POS, 32'h15);
    chk(pos, 1'b0);
    foreach (v[i]) begin
      wr(`SSO_A_WARN, v[i]);
      chk({gw, bw}, x[i]);
    end
    $display("range and warning end");
  endtask
  task automatic t_torq();
    wr(`SSO_A_TLIM1, 32'h64);
    wr(`SSO_A_TORQ, 32'h63);
    chk(tl, 1'b0);
    wr(`SSO_A_TORQ, 32'h64);
    chk(tl, 1'b1);
    wr(`SSO_A_TLIM1, 32'hFFFF);
    wr(`SSO_A_TLIM2, 32'h64);
    chk(tl, 1'b1);
    wr(`SSO_A_TLIM2, 32'hFFFF);
    atl <= 10'h001;
    wr(`SSO_A_CTRL, 32'h20);
    chk(tl, 1'b1);
    $display("torque end");
  endtask
  task automatic t_stop();
    wr(`SSO_A_CTRL, 32'h0);
    press(4'h1);
    chk(ts, 1'b0);
    wr(`SSO_A_CTRL, 32'h10);
    press(4'h1);
    chk(ts, 1'b1);
    press(4'h8);
    chk(ts, 1'b0);
    $display("stop end");
  endtask
  task automatic t_prog();
    wr(`SSO_A_OFFT1, 32'h0);
    wr(`SSO_A_OFFT2, 32'h3);
    wr(`SSO_A_OFFT3, 32'h0);
    for (int i = 1; i < 4; i++) begin
      wr(`SSO_A_PCMD, 32'h100 | i);
      chk(outs[i-1], 1'b1);
    end
    repeat (40) @(posedge clk);
    chk(outs, 3'h5);
    xfer(1'b0, `SSO_A_STAT, 32'h0);
    chk(rd[7:5], 3'h5);
    chk(e, 1'b0);
    wr(`SSO_A_PCMD, 32'h200);
    chk(outs, 3'h0);
    xfer(1'b0, `SSO_A_IRQS, 32'h0);
    wr(`SSO_A_IRQM, 32'h20);
    wr(`SSO_A_PCMD, 32'h103);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    wr(`SSO_A_PCMD, 32'h101);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    xfer(1'b0, `SSO_A_IRQS, 32'h0);
    chk(rd[7:5], 3'h5);
    repeat (4) @(posedge clk);
    chk(irq, 1'b0);
    xfer(1'b0, 12'h040, 32'h0);
    chk(e, 1'b1);
    chk(rd, 32'h0);
    $display("program and irq end");
  endtask
  task automatic results();
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // far beyond the roughly 370 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_misc();
    t_torq();
    t_stop();
    t_prog();
    results();
  end
endmodule // tb_sso_status
`default_nettype wire
